// ==== snt_defs.svh ====
// offsets, field positions, reset values for the transition filter block
`ifndef SNT_DEFS_SVH
`define SNT_DEFS_SVH

// register offsets inside one group window
`define SNT_OFF_COND 5'h00
`define SNT_OFF_NTR 5'h04
`define SNT_OFF_EVT 5'h08
`define SNT_OFF_MASK 5'h0C
// group windows: oper 0x00, trig 0x20, arm 0x40, seq 0x60
`define SNT_GRP_OPER 2'h0
`define SNT_GRP_TRIG 2'h1
`define SNT_GRP_ARM 2'h2
`define SNT_GRP_SEQ 2'h3
// implemented bit positions of each group
`define SNT_IMPL_OPER 16'h0462
`define SNT_IMPL_TRIG 16'h0002
`define SNT_IMPL_ARM 16'h0002
`define SNT_IMPL_SEQ 16'h0006
// field positions
`define SNT_B_FIRST_SEQ 1
`define SNT_B_FIRST_ARM_LAYER 1
`define SNT_B_SECOND_ARM_LAYER 2
`define SNT_B_OPER_TRIG 5
`define SNT_B_OPER_IDLE 10
// reset values
`define SNT_NTR_RST 16'h0000
`define SNT_EVT_RST 16'h0000
`define SNT_MASK_RST 16'h0000
`define SNT_RDATA_RST 32'h0000_0000

`endif

// ==== snt_pkg.sv ====
// types shared by the transition filter block
package snt_pkg;

  // apb request fields held by the master through a transfer
  typedef struct packed {
    logic [31:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
  } snt_apb_req_t;

  // real-time condition inputs, one word per group
  typedef struct packed {
    logic [15:0] seq;
    logic [15:0] arm;
    logic [15:0] trig;
    logic [15:0] oper;
  } snt_cond_t;

  // register selected inside a group window
  typedef enum logic [2:0] {
    SNT_SEL_COND = 3'h0,
    SNT_SEL_NTR = 3'h1,
    SNT_SEL_EVT = 3'h3,
    SNT_SEL_MASK = 3'h2,
    SNT_SEL_NONE = 3'h6
  } snt_sel_t;

endpackage

// ==== snt_sync.sv ====
// two-flop synchroniser for the condition inputs
module snt_sync #(
  parameter int W = 64
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      meta_q <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule // snt_sync

// ==== snt_group.sv ====
// one status group: condition view, ntr filter, sticky events, mask
`include "snt_defs.svh"

module snt_group #(
  parameter logic [15:0] IMPL = 16'hFFFF
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic [15:0] i_cond,
  input wire logic i_ntr_we,
  input wire logic i_evt_w1c,
  input wire logic i_mask_we,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_cond,
  output logic [15:0] o_ntr,
  output logic [15:0] o_evt,
  output logic [15:0] o_mask
);

  logic [15:0] prev_q;
  logic [15:0] fall;

  // live view, unused bits zero
  assign o_cond = i_cond & IMPL;

  // previous condition for edge detection
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      prev_q <= '0;
    else
      prev_q <= o_cond;
  end

  // 1 to 0 change on an enabled bit
  assign fall = prev_q & ~o_cond & o_ntr;

  // negative transition filter, cleared at power-up
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_ntr <= `SNT_NTR_RST;
    else if (i_ntr_we)
      o_ntr <= i_wdata & IMPL;
  end

  // sticky events, set wins over write-one clear
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_evt <= `SNT_EVT_RST;
    else if (i_evt_w1c)
      o_evt <= (o_evt & ~i_wdata) | fall;
    else
      o_evt <= o_evt | fall;
  end

  // interrupt mask
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_mask <= `SNT_MASK_RST;
    else if (i_mask_we)
      o_mask <= i_wdata & IMPL;
  end

endmodule // snt_group

// ==== snt_top.sv ====
// apb register bank with negative transition filters and condition queries
//
// Design decisions made here: the register addresses and the APB register port.
`include "snt_defs.svh"

module snt_top (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire snt_pkg::snt_apb_req_t i_apb,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire snt_pkg::snt_cond_t i_cond,
  output logic o_irq
);
  import snt_pkg::*;

  localparam logic [15:0] IMPL [4] = '{`SNT_IMPL_OPER, `SNT_IMPL_TRIG,
                                       `SNT_IMPL_ARM, `SNT_IMPL_SEQ};

  logic [63:0] cond_raw;
  logic [63:0] cond_flat;
  logic [15:0] cond_s [4];
  logic [15:0] cond_v [4];
  logic [15:0] ntr [4];
  logic [15:0] evt [4];
  logic [15:0] mask [4];
  snt_sel_t sel;
  logic [1:0] grp;
  logic hit;
  logic setup;
  logic wr;
  logic [15:0] rd_val;

  ////////////////////////////////////////////////////////////////////////
  // condition input synchronisation

  assign cond_raw = {i_cond.seq, i_cond.arm, i_cond.trig, i_cond.oper};

  snt_sync #(.W(64)) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_async(cond_raw),
    .o_sync(cond_flat)
  );

  ////////////////////////////////////////////////////////////////////////
  // address decode

  assign grp = i_apb.paddr[6:5];

  // pick the register inside the group window
  always_comb
  begin
    if (i_apb.paddr[31:7] != 25'h000_0000)
      sel = SNT_SEL_NONE;
    else if (i_apb.paddr[4:0] == `SNT_OFF_COND)
      sel = SNT_SEL_COND;
    else if (i_apb.paddr[4:0] == `SNT_OFF_NTR)
      sel = SNT_SEL_NTR;
    else if (i_apb.paddr[4:0] == `SNT_OFF_EVT)
      sel = SNT_SEL_EVT;
    else if (i_apb.paddr[4:0] == `SNT_OFF_MASK)
      sel = SNT_SEL_MASK;
    else
      sel = SNT_SEL_NONE;
  end

  assign hit = (sel != SNT_SEL_NONE);
  assign setup = i_psel && !i_penable;
  assign wr = i_psel && i_penable && i_apb.pwrite && hit;

  // zero wait states
  assign o_pready = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // the four status groups

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : gen_grp
      assign cond_s[g] = cond_flat[16*g +: 16];
      snt_group #(.IMPL(IMPL[g])) u_grp (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_cond(cond_s[g]),
        .i_ntr_we(wr && grp == 2'(g) && sel == SNT_SEL_NTR),
        .i_evt_w1c(wr && grp == 2'(g) && sel == SNT_SEL_EVT),
        .i_mask_we(wr && grp == 2'(g) && sel == SNT_SEL_MASK),
        .i_wdata(i_apb.pwdata[15:0]),
        .o_cond(cond_v[g]),
        .o_ntr(ntr[g]),
        .o_evt(evt[g]),
        .o_mask(mask[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // read path

  // read mux, no side effect on any register
  always_comb
  begin
    if (sel == SNT_SEL_COND)
      rd_val = cond_v[grp];
    else if (sel == SNT_SEL_NTR)
      rd_val = ntr[grp];
    else if (sel == SNT_SEL_EVT)
      rd_val = evt[grp];
    else if (sel == SNT_SEL_MASK)
      rd_val = mask[grp];
    else
      rd_val = 16'h0000;
  end

  // read data captured in the setup cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_prdata <= `SNT_RDATA_RST;
    else if (setup && !i_apb.pwrite)
      o_prdata <= {16'h0000, rd_val};
  end

  // error flag for unmapped addresses
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_pslverr <= 1'b0;
    else if (setup)
      o_pslverr <= !hit;
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt

  // level while any unmasked event is set
  always_comb
  begin
    o_irq = 1'b0;
    for (int k = 0; k < 4; k++)
      o_irq = o_irq | (|(evt[k] & mask[k]));
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);

  logic [15:0] ntr_oper_w;
  logic oper_trig_prev_q;
  logic oper_trig_fall;
  logic [1:0] rst_age_q;
  assign ntr_oper_w = ntr[0];

  // trigger bit of the oper view one cycle back
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      oper_trig_prev_q <= 1'b0;
    else
      oper_trig_prev_q <= cond_v[0][`SNT_B_OPER_TRIG];
  end

  // enabled 1 to 0 change of that bit
  assign oper_trig_fall = oper_trig_prev_q
    && !cond_v[0][`SNT_B_OPER_TRIG] && ntr[0][`SNT_B_OPER_TRIG];

  // cycles since reset release, saturating at three
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      rst_age_q <= 2'h0;
    else if (rst_age_q != 2'h3)
      rst_age_q <= rst_age_q + 2'h1;
  end

  sequence s_rd_setup(logic [31:0] a);
    i_psel && !i_penable && !i_apb.pwrite && i_apb.paddr == a;
  endsequence

  sequence s_wr_access(logic [31:0] a, logic [31:0] d);
    i_psel && i_penable && i_apb.pwrite && i_apb.paddr == a
      && i_apb.pwdata == d;
  endsequence

  property p_trig_leave;
    $fell(cond_v[1][`SNT_B_FIRST_SEQ]) && ntr[1][`SNT_B_FIRST_SEQ]
      |=> evt[1][`SNT_B_FIRST_SEQ];
  endproperty
  a_trig_leave: assert property (p_trig_leave)
    else $error("trigger leave did not set event");

  property p_arm_leave;
    $fell(cond_v[2][`SNT_B_FIRST_SEQ]) && ntr[2][`SNT_B_FIRST_SEQ]
      |=> evt[2][`SNT_B_FIRST_SEQ] [*2];
  endproperty
  a_arm_leave: assert property (p_arm_leave)
    else $error("arm leave did not set event");

  property p_seq_leave;
    ($fell(cond_v[3][`SNT_B_FIRST_ARM_LAYER])
      && ntr[3][`SNT_B_FIRST_ARM_LAYER] |=> evt[3][`SNT_B_FIRST_ARM_LAYER])
    and ($fell(cond_v[3][`SNT_B_SECOND_ARM_LAYER])
      && ntr[3][`SNT_B_SECOND_ARM_LAYER]
      |=> evt[3][`SNT_B_SECOND_ARM_LAYER]);
  endproperty
  a_seq_leave: assert property (p_seq_leave)
    else $error("layer leave did not set sequence event");

  property p_write_1026;
    s_wr_access(32'h0000_0004, 32'h0000_0402)
      |=> ntr_oper_w == 16'h0402;
  endproperty
  a_write_1026: assert property (p_write_1026)
    else $error("ntr write of 1026 gave wrong bits");

  property p_ntr_read;
    s_rd_setup(32'h0000_0004) ##1 i_psel && i_penable
      |-> o_prdata == {16'h0000, $past(ntr_oper_w)};
  endproperty
  a_ntr_read: assert property (p_ntr_read)
    else $error("ntr read returned wrong value");

  property p_cond_read(logic [31:0] a, int k);
    s_rd_setup(a) |=> o_prdata[15:0] == $past(cond_v[k])
      && o_prdata[31:16] == 16'h0000;
  endproperty
  a_oper_cond: assert property (p_cond_read(32'h0000_0000, 0))
    else $error("operation condition read wrong");
  a_trig_cond: assert property (p_cond_read(32'h0000_0020, 1))
    else $error("trigger condition read wrong");
  a_arm_cond: assert property (p_cond_read(32'h0000_0040, 2))
    else $error("arm condition read wrong");
  a_seq_cond: assert property (p_cond_read(32'h0000_0060, 3))
    else $error("sequence condition read wrong");

  property p_only_fall;
    !evt[0][`SNT_B_OPER_TRIG] && !oper_trig_fall
      |=> !evt[0][`SNT_B_OPER_TRIG];
  endproperty
  a_only_fall: assert property (p_only_fall)
    else $error("event set without a falling condition");

  property p_ntr_hold;
    !wr |=> $stable(ntr_oper_w) && $stable(ntr[3]);
  endproperty
  a_ntr_hold: assert property (p_ntr_hold)
    else $error("filter changed without a write");

  property p_cond_live;
    rst_age_q == 2'h3 |-> {cond_v[3], cond_v[2], cond_v[1], cond_v[0]}
      == ($past(cond_raw, 2) & {`SNT_IMPL_SEQ, `SNT_IMPL_ARM,
      `SNT_IMPL_TRIG, `SNT_IMPL_OPER});
  endproperty
  a_cond_live: assert property (p_cond_live)
    else $error("condition view does not follow status");

  property p_unused_zero;
    (ntr[0] & ~`SNT_IMPL_OPER) == 16'h0000
      && (evt[3] & ~`SNT_IMPL_SEQ) == 16'h0000
      && (mask[1] & ~`SNT_IMPL_TRIG) == 16'h0000;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused bit is set");

  // unmapped read answers error and zero
  property p_bad_read;
    s_rd_setup(32'h0000_0010) |=> o_pslverr && o_prdata == 32'h0000_0000;
  endproperty
  a_bad_read: assert property (p_bad_read)
    else $error("unmapped read did not flag an error");

  // arm event stays clear without an enabled fall
  property p_arm_only_fall;
    !evt[2][`SNT_B_FIRST_SEQ]
      && !($fell(cond_v[2][`SNT_B_FIRST_SEQ]) && ntr[2][`SNT_B_FIRST_SEQ])
      |=> !evt[2][`SNT_B_FIRST_SEQ];
  endproperty
  a_arm_only_fall: assert property (p_arm_only_fall)
    else $error("arm event set without a falling condition");

  // write one clears a trigger event unless a new fall lands
  property p_trig_clear;
    s_wr_access(32'h0000_0028, 32'h0000_0002)
      ##0 !($fell(cond_v[1][`SNT_B_FIRST_SEQ]) && ntr[1][`SNT_B_FIRST_SEQ])
      |=> !evt[1][`SNT_B_FIRST_SEQ];
  endproperty
  a_trig_clear: assert property (p_trig_clear)
    else $error("trigger event did not clear on write one");

endmodule // snt_top

// ==== snt_host_model.sv ====
// apb host model that queries and programs the register bank
module snt_host_model (
  input wire logic i_sys_clk,
  input wire logic i_pready,
  input wire logic [31:0] i_prdata,
  input wire logic i_pslverr,
  output logic o_psel,
  output logic o_penable,
  output snt_pkg::snt_apb_req_t o_apb,
  output logic o_hang
);
  timeunit 1ns;
  timeprecision 1ps;
  import snt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // idle bus at time zero
  initial
  begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_apb = '0;
    o_hang = 1'b0;
  end

  // one transfer: setup, access held until pready, then release
  task automatic xfer(input logic [31:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    int n;
    @(posedge i_sys_clk);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_apb <= '{a, w, d};
    @(posedge i_sys_clk);
    o_penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge i_sys_clk);
      n++;
    end while (i_pready !== 1'b1 && n < 16);
    q = i_prdata; // taken at the pready edge, or at the sixteenth access edge on timeout
    e = i_pslverr;
    if (i_pready !== 1'b1)
      o_hang <= 1'b1;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_apb <= ~o_apb; // released lines must not keep old value
  endtask
endmodule // snt_host_model

// ==== snt_top_tb.sv ====
// self-checking bench for the transition filter register bank
`include "snt_defs.svh"

module snt_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import snt_pkg::*;

  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel, penable, pready, pslverr, irq, hang;
  logic [31:0] prdata;
  snt_apb_req_t apb;
  snt_cond_t cond = '0;
  int num_errors = 0;
  int samples_checked = 0;

  ////////////////////////////////////////////////////////////////////////////
  // clock, design and host
  always #2 sys_clk = ~sys_clk;

  snt_top dut (.i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_psel(psel),
    .i_penable(penable), .i_apb(apb), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .i_cond(cond), .o_irq(irq));

  snt_host_model u_host (.i_sys_clk(sys_clk), .i_pready(pready),
    .i_prdata(prdata), .i_pslverr(pslverr), .o_psel(psel),
    .o_penable(penable), .o_apb(apb), .o_hang(hang));

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge hang)
  begin
    num_errors++;
    complete_run();
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] ra(input logic [1:0] g,
                                     input logic [4:0] o);
    return {25'h0, g, o};
  endfunction

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    u_host.xfer(a, 1'b1, d, q, e);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    u_host.xfer(a, 1'b0, 32'h0, q, e);
    check(q, exp);
    check({31'h0, e}, 32'h0);
  endtask

  task automatic settle;
    repeat (6) @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    for (int g = 0; g < 4; g++)
    begin
      rd_chk(ra(2'(g), `SNT_OFF_NTR), 32'h0);
      rd_chk(ra(2'(g), `SNT_OFF_EVT), 32'h0);
    end
    check({31'h0, irq}, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_ntr;
    wr(ra(`SNT_GRP_OPER, `SNT_OFF_NTR), 32'h0000_0402);
    rd_chk(ra(`SNT_GRP_OPER, `SNT_OFF_NTR), 32'h0000_0402);
    wr(ra(`SNT_GRP_OPER, `SNT_OFF_NTR), 32'h0000_0060);
    rd_chk(ra(`SNT_GRP_OPER, `SNT_OFF_NTR), 32'h0000_0060);
    wr(ra(`SNT_GRP_OPER, `SNT_OFF_NTR), 32'hFFFF_FFFF);
    rd_chk(ra(`SNT_GRP_OPER, `SNT_OFF_NTR), 32'h0000_0462);
    wr(ra(`SNT_GRP_SEQ, `SNT_OFF_NTR), 32'hFFFF_FFFF);
    rd_chk(ra(`SNT_GRP_SEQ, `SNT_OFF_NTR), 32'h0000_0006);
    wr(ra(`SNT_GRP_OPER, `SNT_OFF_NTR), 32'h0000_0020);
    $display("test ntr done");
  endtask

  task automatic t_cond;
    @(posedge sys_clk);
    cond <= '1;
    settle();
    rd_chk(ra(`SNT_GRP_OPER, `SNT_OFF_COND), 32'h0462);
    rd_chk(ra(`SNT_GRP_OPER, `SNT_OFF_COND), 32'h0462);
    rd_chk(ra(`SNT_GRP_TRIG, `SNT_OFF_COND), 32'h0002);
    rd_chk(ra(`SNT_GRP_ARM, `SNT_OFF_COND), 32'h0002);
    rd_chk(ra(`SNT_GRP_SEQ, `SNT_OFF_COND), 32'h0006);
    wr(ra(`SNT_GRP_TRIG, `SNT_OFF_COND), 32'h0);
    rd_chk(ra(`SNT_GRP_TRIG, `SNT_OFF_COND), 32'h0002);
    for (int g = 0; g < 4; g++)
      rd_chk(ra(2'(g), `SNT_OFF_EVT), 32'h0);
    $display("test cond done");
  endtask

  task automatic t_fall;
    wr(ra(`SNT_GRP_TRIG, `SNT_OFF_NTR), 32'h2);
    wr(ra(`SNT_GRP_ARM, `SNT_OFF_NTR), 32'h2);
    @(posedge sys_clk);
    cond.oper <= 16'hFFBF; // bit 6 not enabled
    cond.trig <= 16'h0;
    settle();
    rd_chk(ra(`SNT_GRP_OPER, `SNT_OFF_EVT), 32'h0);
    rd_chk(ra(`SNT_GRP_TRIG, `SNT_OFF_EVT), 32'h2);
    rd_chk(ra(`SNT_GRP_ARM, `SNT_OFF_EVT), 32'h0);
    rd_chk(ra(`SNT_GRP_OPER, `SNT_OFF_COND), 32'h0422);
    cond.arm <= 16'h0;
    cond.seq <= 16'hFFFD;
    cond.oper <= 16'h0;
    settle();
    rd_chk(ra(`SNT_GRP_ARM, `SNT_OFF_EVT), 32'h2);
    rd_chk(ra(`SNT_GRP_SEQ, `SNT_OFF_EVT), 32'h2);
    rd_chk(ra(`SNT_GRP_OPER, `SNT_OFF_EVT), 32'h20);
    cond.seq <= 16'h0;
    settle();
    rd_chk(ra(`SNT_GRP_SEQ, `SNT_OFF_EVT), 32'h6);
    $display("test fall done");
  endtask

  task automatic t_irq;
    check({31'h0, irq}, 32'h0);
    wr(ra(`SNT_GRP_TRIG, `SNT_OFF_MASK), 32'h2);
    repeat (2) @(posedge sys_clk);
    check({31'h0, irq}, 32'h1);
    wr(ra(`SNT_GRP_TRIG, `SNT_OFF_EVT), 32'h2);
    repeat (2) @(posedge sys_clk);
    check({31'h0, irq}, 32'h0);
    rd_chk(ra(`SNT_GRP_TRIG, `SNT_OFF_EVT), 32'h0);
    $display("test irq done");
  endtask

  task automatic t_bad;
    logic [31:0] q;
    logic e;
    u_host.xfer(32'h0000_0010, 1'b0, 32'h0, q, e);
    check(q, 32'h0);
    check({31'h0, e}, 32'h1);
    wr(32'h0000_0084, 32'hFFFF);
    rd_chk(ra(`SNT_GRP_OPER, `SNT_OFF_NTR), 32'h20);
    $display("test unmapped done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    t_ntr();
    t_cond();
    t_fall();
    t_irq();
    t_bad();
    // second reset in mid-run clears every filter and event
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    complete_run();
  end
endmodule // snt_top_tb
